// ---- logic/alu_pkg.sv ----
// Constants and types for the compare / adjust / decrement datapath.
// Assumes a 16-bit core; flag word layout is local to this block.
package alu_pkg;
    localparam int DATA_W = 16;
    localparam logic [15:0] SIGN_THRESH = 16'h8000;
    localparam logic [15:0] EXT_ONES = 16'hffff;
    localparam logic [15:0] EXT_ZERO = 16'h0000;
    localparam logic [7:0] NIBBLE_MASK = 8'h0f;
    localparam logic [7:0] NIBBLE_MAX = 8'h09;
    localparam logic [7:0] LOW_ADJ = 8'h06;
    localparam logic [7:0] BYTE_MAX_BCD = 8'h9f;
    localparam logic [7:0] HIGH_ADJ = 8'h60;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [15:0] ONE = 16'h0001;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // Flag bit positions inside flags word
    localparam int F_CARRY = 0;
    localparam int F_PARITY = 1;
    localparam int F_AUX = 2;
    localparam int F_ZERO = 3;
    localparam int F_SIGN = 4;
    localparam int F_OVER = 5;
    localparam int FLAGS_W = 6;
    localparam logic [5:0] RESET_FLAGS = 6'h00;

    typedef enum logic [5:0] {
        OP_COMPARE = 6'b000001,
        OP_STRING_COMPARE = 6'b000010,
        OP_WORD_SIGN_EXTEND = 6'b000100,
        OP_BCD_ADD_ADJUST = 6'b001000,
        OP_BCD_SUB_ADJUST = 6'b010000,
        OP_MINUS_ONE = 6'b100000
    } op_sel_t;
endpackage

// ---- logic/compare_adjust_decrement_alu.sv ----
// Compare, string compare, word sign extend, decimal adjusts and decrement.
// Assumes the sequencer presents operands with a one-cycle start pulse and
// takes results one cycle later; repeat loop control lives in the sequencer.
// Functional notes
// RL1 - Compare sets flags from destination minus source; greater test follows.
// RL2 - Compare accepts any operand pairing; operands arrive already fetched.
// RL3 - String compare subtracts source element from dest, updates six flags.
// RL4 - After string compare step both indexes up or down by element step.
// RL5 - String compare repeats per element under a repeat prefix.
// RL6 - Word sign extend fills extension word from accumulator sign; flags unchanged.
// RL7 - Add adjust adds 6 when low nibble over 9 or aux carry.
// RL8 - Add adjust adds 60H when value over 9FH or carry.
// RL9 - Subtract adjust subtracts 6 when low nibble over 9 or aux carry.
// RL10 - Subtract adjust subtracts 60H when value over 9FH or carry.
// RL11 - Decimal adjusts update parity sign zero; overflow undefined; others kept. Code also sets aux and carry when the matching step fires.
// RL12 - Decrement updates aux overflow parity sign zero; carry kept.
// RL13 - Decrement treats its operand as unsigned binary.
// RL14 - Element step is one for bytes and two for words.
`timescale 1ns/1ns
module compare_adjust_decrement_alu
    import alu_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Operation request
    input wire logic start,
    input wire op_sel_t op_sel,
    input wire logic word_size,
    input wire logic [15:0] dest_operand,
    input wire logic [15:0] src_operand,
    input wire logic [15:0] source_index_in,
    input wire logic [15:0] dest_index_in,
    input wire logic step_backward_flag,
    input wire logic [5:0] flags_in,
    // Results
    output logic done,
    output logic [15:0] result,
    output logic result_write,
    output logic [15:0] source_index,
    output logic [15:0] dest_index,
    output logic index_write,
    output logic [5:0] flags
);
    logic rst_meta;
    logic rst_sync_n;

    // Reset released through two flops so all state leaves reset together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    function automatic logic even_parity(input logic [7:0] v);
        even_parity = ~^v;
    endfunction

    // Subtract a - b at byte or word size; returns {ovf, aux, carry, diff}
    function automatic logic [18:0] sub_sz(input logic [15:0] a, input logic [15:0] b,
                                           input logic w);
        logic [16:0] d;
        logic ov;
        logic ax;
        logic cy;
        d = {1'b0, a} - {1'b0, b};
        ax = (a[3:0] < b[3:0]);
        if (w) begin
            cy = d[16];
            ov = (a[15] ^ b[15]) & (a[15] ^ d[15]);
        end else begin
            cy = (a[7:0] < b[7:0]);
            ov = (a[7] ^ b[7]) & (a[7] ^ d[7]);
        end
        sub_sz = {ov, ax, cy, d[15:0]};
    endfunction

    logic next_done;
    logic [15:0] next_result;
    logic next_result_write;
    logic [15:0] next_source_index;
    logic [15:0] next_dest_index;
    logic next_index_write;
    logic [5:0] next_flags;

    logic [18:0] diff;
    logic [15:0] step;
    logic [7:0] al;
    logic [7:0] al_lo;
    logic aux_hit;
    logic car_hit;
    logic [15:0] res_sz;

    always_comb begin
        next_done = 1'b0;
        next_result = result;
        next_result_write = 1'b0;
        next_source_index = source_index;
        next_dest_index = dest_index;
        next_index_write = 1'b0;
        next_flags = flags_in;
        diff = 19'h00000;
        step = word_size ? STEP_WORD : STEP_BYTE; // [RL14]
        al = dest_operand[7:0];
        al_lo = dest_operand[7:0];
        aux_hit = 1'b0;
        car_hit = 1'b0;
        res_sz = 16'h0000;
        if (start) begin
            next_done = 1'b1;
            case (op_sel)
                OP_COMPARE, OP_STRING_COMPARE: begin
                    // Difference sets flags and result; result_write stays low, so operands are never written
                    diff = sub_sz(dest_operand, src_operand, word_size); // [RL1] [RL2] [RL3]
                    res_sz = word_size ? diff[15:0] : {8'h00, diff[7:0]};
                    next_result = res_sz;
                    next_flags[F_CARRY] = diff[16];
                    next_flags[F_AUX] = diff[17];
                    next_flags[F_OVER] = diff[18];
                    next_flags[F_PARITY] = even_parity(diff[7:0]);
                    next_flags[F_ZERO] = (res_sz == 16'h0000);
                    next_flags[F_SIGN] = word_size ? diff[15] : diff[7];
                    if (op_sel == OP_STRING_COMPARE) begin
                        // Each element is a fresh request, so repeats just reissue
                        next_index_write = 1'b1; // [RL5]
                        if (step_backward_flag) begin // [RL4]
                            next_source_index = source_index_in - step;
                            next_dest_index = dest_index_in - step;
                        end else begin
                            next_source_index = source_index_in + step;
                            next_dest_index = dest_index_in + step;
                        end
                    end
                end
                OP_WORD_SIGN_EXTEND: begin
                    // Flags pass through untouched
                    next_result = (dest_operand < SIGN_THRESH) ? EXT_ZERO : EXT_ONES; // [RL6]
                    next_result_write = 1'b1;
                end
                OP_BCD_ADD_ADJUST, OP_BCD_SUB_ADJUST: begin
                    aux_hit = ((al & NIBBLE_MASK) > NIBBLE_MAX) | flags_in[F_AUX];
                    if (aux_hit) begin
                        al_lo = (op_sel == OP_BCD_ADD_ADJUST) ? al + LOW_ADJ // [RL7]
                                                              : al - LOW_ADJ; // [RL9]
                        next_flags[F_AUX] = 1'b1;
                    end
                    // Second test looks at the value after the low-nibble step
                    car_hit = (al_lo > BYTE_MAX_BCD) | flags_in[F_CARRY];
                    if (car_hit) begin
                        al = (op_sel == OP_BCD_ADD_ADJUST) ? al_lo + HIGH_ADJ // [RL8]
                                                           : al_lo - HIGH_ADJ; // [RL10]
                        next_flags[F_CARRY] = 1'b1;
                    end else begin
                        al = al_lo;
                    end
                    // Overflow is undefined here; it is simply cleared
                    next_flags[F_OVER] = 1'b0; // [RL11]
                    next_flags[F_PARITY] = even_parity(al);
                    next_flags[F_ZERO] = (al == 8'h00);
                    next_flags[F_SIGN] = al[7];
                    next_result = {dest_operand[15:8], al};
                    next_result_write = 1'b1;
                end
                OP_MINUS_ONE: begin
                    diff = sub_sz(dest_operand, ONE, word_size); // [RL12] [RL13]
                    res_sz = word_size ? diff[15:0] : {dest_operand[15:8], diff[7:0]};
                    next_result = res_sz;
                    next_result_write = 1'b1;
                    next_flags[F_AUX] = diff[17];
                    next_flags[F_OVER] = diff[18];
                    next_flags[F_PARITY] = even_parity(diff[7:0]);
                    next_flags[F_ZERO] = word_size ? (diff[15:0] == 16'h0000)
                                                   : (diff[7:0] == 8'h00);
                    next_flags[F_SIGN] = word_size ? diff[15] : diff[7];
                end
                default: begin
                    next_done = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done <= 1'b0;
            result <= RESET_WORD;
            result_write <= 1'b0;
            source_index <= RESET_WORD;
            dest_index <= RESET_WORD;
            index_write <= 1'b0;
            flags <= RESET_FLAGS;
        end else if (clk_en) begin
            done <= next_done;
            result <= next_result;
            result_write <= next_result_write;
            source_index <= next_source_index;
            dest_index <= next_dest_index;
            index_write <= next_index_write;
            flags <= next_flags;
        end
    end

    // Checks
    chk_cmp_greater: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL1]
        (clk_en && start && op_sel == OP_COMPARE && word_size
         && $signed(dest_operand) > $signed(src_operand))
        |=> (!flags[F_ZERO] && flags[F_SIGN] == flags[F_OVER]))
        else $error("compare greater flags wrong");
    chk_cmp_notgreater: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL1]
        (clk_en && start && op_sel == OP_COMPARE && word_size
         && $signed(dest_operand) <= $signed(src_operand))
        |=> (flags[F_ZERO] || flags[F_SIGN] != flags[F_OVER]))
        else $error("compare not greater flags wrong");
    chk_cmp_answer: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL2]
        (clk_en && start && op_sel == OP_COMPARE)
        |=> (done && !result_write && !index_write))
        else $error("compare answer wrong");
    chk_str_flags: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL3]
        (clk_en && start && op_sel == OP_STRING_COMPARE && word_size)
        |=> (flags[F_CARRY] == ($past(dest_operand) < $past(src_operand))
             && flags[F_ZERO] == ($past(dest_operand) == $past(src_operand))
             && flags[F_SIGN] == result[15]))
        else $error("string compare flags wrong");
    chk_src_step: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL4]
        (clk_en && start && op_sel == OP_STRING_COMPARE && step_backward_flag)
        |=> (source_index == $past(source_index_in) - $past(step)
             && dest_index == $past(dest_index_in) - $past(step)))
        else $error("backward step wrong");
    chk_step_size: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL14]
        (clk_en && start && op_sel == OP_STRING_COMPARE && !step_backward_flag)
        |=> (source_index == $past(source_index_in) + ($past(word_size) ? STEP_WORD : STEP_BYTE)
         && dest_index == $past(dest_index_in) + ($past(word_size) ? STEP_WORD : STEP_BYTE)))
        else $error("forward step size wrong");
    chk_str_answer: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL5]
        (clk_en && start && op_sel == OP_STRING_COMPARE) |=> (done && index_write))
        else $error("string element not answered");
    chk_step_dir: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL4]
        (clk_en && start && op_sel == OP_STRING_COMPARE)
        |=> (index_write && dest_index - $past(dest_index_in) ==
             ($past(step_backward_flag) ? -$past(step) : $past(step))))
        else $error("index step wrong");
    chk_cmp_nowrite: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL3]
        (clk_en && start && op_sel == OP_STRING_COMPARE) |=> !result_write)
        else $error("string compare wrote operand");
    chk_ext_value: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL6]
        (clk_en && start && op_sel == OP_WORD_SIGN_EXTEND)
        |=> (result == ($past(dest_operand[15]) ? EXT_ONES : EXT_ZERO)
             && flags == $past(flags_in)))
        else $error("sign extend wrong");
    chk_daa_aux: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL7]
        (clk_en && start && op_sel == OP_BCD_ADD_ADJUST && dest_operand[3:0] > 4'h9)
        |=> flags[F_AUX])
        else $error("add adjust aux not set");
    chk_daa_carry: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL8]
        (clk_en && start && op_sel == OP_BCD_ADD_ADJUST && flags_in[F_CARRY]
         && !flags_in[F_AUX] && dest_operand[3:0] <= 4'h9)
        |=> (flags[F_CARRY] && result[7:0] == $past(dest_operand[7:0]) + HIGH_ADJ))
        else $error("add adjust high step wrong");
    chk_das_low: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL9]
        (clk_en && start && op_sel == OP_BCD_SUB_ADJUST && flags_in[F_AUX]
         && !flags_in[F_CARRY] && dest_operand[7:0] == 8'h36)
        |=> (result[7:0] == 8'h30))
        else $error("sub adjust low step wrong");
    chk_dec_carry: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL12]
        (clk_en && start && op_sel == OP_MINUS_ONE)
        |=> (flags[F_CARRY] == $past(flags_in[F_CARRY])
             && result_write && done))
        else $error("decrement touched carry");
    chk_dec_value: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL13]
        (clk_en && start && op_sel == OP_MINUS_ONE && word_size)
        |=> (result == $past(dest_operand) - ONE))
        else $error("decrement value wrong");
    // Adjusts and decrement, flag and value side
    chk_das_high: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL10]
        (clk_en && start && op_sel == OP_BCD_SUB_ADJUST && flags_in[F_CARRY]
         && !flags_in[F_AUX] && dest_operand[3:0] <= 4'h9)
        |=> (flags[F_CARRY] && result[7:0] == $past(dest_operand[7:0]) - HIGH_ADJ))
        else $error("sub adjust high step wrong");
    chk_adj_plain: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL8] [RL10]
        (clk_en && start && (op_sel == OP_BCD_ADD_ADJUST || op_sel == OP_BCD_SUB_ADJUST)
         && !flags_in[F_CARRY] && !flags_in[F_AUX] && dest_operand[3:0] <= 4'h9
         && dest_operand[7:0] <= BYTE_MAX_BCD)
        |=> (!flags[F_CARRY] && !flags[F_AUX] && result[7:0] == $past(dest_operand[7:0])))
        else $error("adjust without cause changed value");
    chk_adj_flags: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL11]
        (clk_en && start && (op_sel == OP_BCD_ADD_ADJUST || op_sel == OP_BCD_SUB_ADJUST))
        |=> (flags[F_SIGN] == result[7] && flags[F_ZERO] == (result[7:0] == 8'h00)
             && flags[F_PARITY] == ~^result[7:0] && !flags[F_OVER]
             && result[15:8] == $past(dest_operand[15:8]) && result_write))
        else $error("adjust flags wrong");
    chk_dec_byte: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL13]
        (clk_en && start && op_sel == OP_MINUS_ONE && !word_size)
        |=> (result == {$past(dest_operand[15:8]), $past(dest_operand[7:0]) - 8'h01}))
        else $error("byte decrement value wrong");
    chk_dec_flags: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL12]
        (clk_en && start && op_sel == OP_MINUS_ONE && word_size)
        |=> (flags[F_ZERO] == (result == 16'h0000) && flags[F_SIGN] == result[15]
             && flags[F_AUX] == ($past(dest_operand[3:0]) == 4'h0)
             && flags[F_OVER] == ($past(dest_operand) == SIGN_THRESH)))
        else $error("decrement flags wrong");
    // Pulses only answer a taken request; a low enable freezes everything
    chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL5]
        (clk_en && !start) |=> (!done && !result_write && !index_write))
        else $error("answer without request");
    chk_hold_frozen: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RL4]
        !clk_en |=> ($stable(source_index) && $stable(dest_index) && $stable(result)
                     && $stable(flags) && $stable(done)))
        else $error("state moved while clock enable low");
endmodule

// ---- testbench/sequencer_model.sv ----
// Sequencer stand-in: holds one request until taken, then captures the answer.
// Assumes a single clock and an answer one enabled edge after the request.
`timescale 1ns/1ns
module sequencer_model
    import alu_pkg::*;
(
    // Clock
    input wire logic clk,
    // Request
    output logic clk_en,
    output logic start,
    output op_sel_t op_sel,
    output logic word_size,
    output logic [15:0] dest_operand,
    output logic [15:0] src_operand,
    output logic [15:0] source_index_in,
    output logic [15:0] dest_index_in,
    output logic step_backward_flag,
    output logic [5:0] flags_in,
    // Answer
    input wire logic done,
    input wire logic [15:0] result,
    input wire logic result_write,
    input wire logic [15:0] source_index,
    input wire logic [15:0] dest_index,
    input wire logic index_write,
    input wire logic [5:0] flags
);
    logic got_done;
    logic got_rw;
    logic got_iw;
    logic [5:0] got_flags;
    logic [15:0] got_result;
    logic [15:0] got_si;
    logic [15:0] got_di;

    initial begin
        clk_en = 1'b1;
        start = 1'b0;
        op_sel = OP_COMPARE;
        {word_size, step_backward_flag, flags_in} = '0;
        {dest_operand, src_operand, source_index_in, dest_index_in} = '0;
    end

    // Slow answers: clk_en held low for the first stall edges while the request stands
    task automatic issue(input op_sel_t op, input logic w, input logic [15:0] d, s, si, di,
                         input logic back, input logic [5:0] fin, input int stall);
        @(posedge clk);
        #1;
        start = 1'b1;
        clk_en = (stall == 0);
        op_sel = op;
        {word_size, step_backward_flag, flags_in} = {w, back, fin};
        {dest_operand, src_operand, source_index_in, dest_index_in} = {d, s, si, di};
        // Release the freeze at the same offset as every other input change
        if (stall > 0) begin
            repeat (stall) @(posedge clk);
            #1;
            clk_en = 1'b1;
        end
        @(posedge clk);
        #1;
        {got_done, got_rw, got_iw, got_flags} = {done, result_write, index_write, flags};
        {got_result, got_si, got_di} = {result, source_index, dest_index};
        start = 1'b0;
        // Stale operands must not look valid after the request
        {dest_operand, src_operand} = ~{d, s};
    endtask
endmodule

// ---- testbench/test_compare_adjust_decrement_alu.sv ----
// Self-checking bench for the compare / adjust / decrement datapath.
// Assumes the sequencer model drives every request input.
`timescale 1ns/1ns
module test_compare_adjust_decrement_alu
    import alu_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en, start, word_size, step_backward_flag, done, result_write, index_write;
    op_sel_t op_sel;
    logic [15:0] dest_operand, src_operand, source_index_in, dest_index_in;
    logic [15:0] result, source_index, dest_index;
    logic [5:0] flags_in, flags;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    compare_adjust_decrement_alu i_compare_adjust_decrement_alu (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .start(start), .op_sel(op_sel), .word_size(word_size),
        .dest_operand(dest_operand), .src_operand(src_operand),
        .source_index_in(source_index_in), .dest_index_in(dest_index_in),
        .step_backward_flag(step_backward_flag), .flags_in(flags_in), .done(done),
        .result(result), .result_write(result_write), .source_index(source_index),
        .dest_index(dest_index), .index_write(index_write), .flags(flags));

    sequencer_model i_sequencer_model (.clk(clk), .clk_en(clk_en), .start(start),
        .op_sel(op_sel), .word_size(word_size), .dest_operand(dest_operand),
        .src_operand(src_operand), .source_index_in(source_index_in),
        .dest_index_in(dest_index_in), .step_backward_flag(step_backward_flag),
        .flags_in(flags_in), .done(done), .result(result), .result_write(result_write),
        .source_index(source_index), .dest_index(dest_index), .index_write(index_write),
        .flags(flags));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Flags of a - b, layout {over, sign, zero, aux, parity, carry}
    function automatic logic [5:0] sub_flags(input logic [15:0] a, b, input logic w, c);
        logic [15:0] r;
        logic sa, sb, sr;
        r = a - b;
        sa = w ? a[15] : a[7];
        sb = w ? b[15] : b[7];
        sr = w ? r[15] : r[7];
        return {(sa != sb) && (sr != sa), sr, (w ? r : {8'h00, r[7:0]}) == 16'h0000,
                a[4] ^ b[4] ^ r[4], ~^r[7:0], c};
    endfunction

    task automatic run(input string what, input op_sel_t op, input logic w,
                       input logic [15:0] d, s, input logic [5:0] fin, input int stall,
                       input logic [15:0] res, input logic [5:0] fl, input logic rw);
        i_sequencer_model.issue(op, w, d, s, 16'h0000, 16'h0000, 1'b0, fin, stall);
        check({what, " done"}, i_sequencer_model.got_done, 1'b1);
        check({what, " result"}, i_sequencer_model.got_result, res);
        check({what, " flags"}, i_sequencer_model.got_flags, fl);
        check({what, " write"}, i_sequencer_model.got_rw, rw);
        check({what, " index write"}, i_sequencer_model.got_iw, 1'b0);
    endtask

    task automatic t_compare();
        logic [15:0] da[5] = '{16'h0005, 16'h0003, 16'h0007, 16'h8000, 16'hff80};
        logic [15:0] sa[5] = '{16'h0003, 16'h0005, 16'h0007, 16'h0001, 16'h0001};
        logic [15:0] r;
        logic [5:0] f;
        logic w, c, gt;
        for (int i = 0; i < 5; i++) begin
            w = (i < 4);
            r = w ? da[i] - sa[i] : {8'h00, da[i][7:0] - sa[i][7:0]};
            c = w ? da[i] < sa[i] : da[i][7:0] < sa[i][7:0];
            run("compare", OP_COMPARE, w, da[i], sa[i], 6'h00, i % 2, r,
                sub_flags(da[i], sa[i], w, c), 1'b0);
            f = i_sequencer_model.got_flags;
            gt = w ? $signed(da[i]) > $signed(sa[i]) : $signed(da[i][7:0]) > $signed(sa[i][7:0]);
            check("greater", !f[3] && (f[4] == f[5]), gt);
        end
        $display("compare test done");
    endtask

    task automatic t_string();
        logic [15:0] si, di, st;
        for (int k = 0; k < 4; k++) begin
            si = 16'h1000;
            di = 16'h2000;
            st = k[0] ? 16'h0002 : 16'h0001;
            for (int e = 0; e < 2; e++) begin
                i_sequencer_model.issue(OP_STRING_COMPARE, k[0], 16'h4321,
                                        16'h4320 + e[15:0], si, di, k[1], 6'h00, 0);
                si = k[1] ? si - st : si + st;
                di = k[1] ? di - st : di + st;
                check("string flags", i_sequencer_model.got_flags,
                      sub_flags(16'h4321, 16'h4320 + e[15:0], k[0], 1'b0));
                check("source index", i_sequencer_model.got_si, si);
                check("dest index", i_sequencer_model.got_di, di);
                check("index write", i_sequencer_model.got_iw, 1'b1);
                check("string write", i_sequencer_model.got_rw, 1'b0);
                check("string done", i_sequencer_model.got_done, 1'b1);
            end
        end
        $display("string compare test done");
    endtask

    task automatic t_extend();
        run("extend", OP_WORD_SIGN_EXTEND, 1'b1, 16'h7fff, 16'h0000, 6'h2a, 0,
            16'h0000, 6'h2a, 1'b1);
        run("extend", OP_WORD_SIGN_EXTEND, 1'b1, 16'h8000, 16'h0000, 6'h15, 0,
            16'hffff, 6'h15, 1'b1);
        $display("sign extend test done");
    endtask

    task automatic t_bcd();
        logic [7:0] av[12] = '{8'hab, 8'h00, 8'h2f, 8'h0b, 8'h45, 8'h45,
                               8'hab, 8'h00, 8'h66, 8'h38, 8'h36, 8'h95};
        logic [5:0] fi[12] = '{6'h00, 6'h05, 6'h01, 6'h00, 6'h01, 6'h00,
                               6'h00, 6'h05, 6'h05, 6'h00, 6'h04, 6'h01};
        logic [7:0] al;
        logic sb, ax, cy;
        for (int i = 0; i < 12; i++) begin
            sb = (i > 5);
            al = av[i];
            ax = al[3:0] > 4'h9 || fi[i][2];
            if (ax)
                al = sb ? al - 8'h06 : al + 8'h06;
            cy = al > 8'h9f || fi[i][0];
            if (cy)
                al = sb ? al - 8'h60 : al + 8'h60;
            run("adjust", sb ? OP_BCD_SUB_ADJUST : OP_BCD_ADD_ADJUST, 1'b0,
                {8'h5a, av[i]}, 16'h0000, fi[i], 0, {8'h5a, al},
                {1'b0, al[7], al == 8'h00, ax, ~^al, cy}, 1'b1);
        end
        $display("decimal adjust test done");
    endtask

    task automatic t_dec();
        logic [15:0] dv[4] = '{16'h0000, 16'h8000, 16'h3480, 16'h1200};
        logic [5:0] fv[4] = '{6'h01, 6'h00, 6'h00, 6'h01};
        logic [15:0] r;
        for (int i = 0; i < 4; i++) begin
            r = i < 2 ? dv[i] - 16'h0001 : {dv[i][15:8], dv[i][7:0] - 8'h01};
            run("decrement", OP_MINUS_ONE, i < 2, dv[i], 16'h0000, fv[i], 0, r,
                sub_flags(dv[i], 16'h0001, i < 2, fv[i][0]), 1'b1);
        end
        $display("decrement test done");
    endtask

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #40000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_compare();
        t_string();
        t_extend();
        t_bcd();
        t_dec();
        print_verdict();
    end
endmodule
